/* File: rtl/dcoel_top.sv */
// dc output enable, lock, event and alarm control with axi4-lite regs
// assumes pins synchronous to core_clk; one write and one read at a time
`timescale 1ns/1ns
`default_nettype none
`include "dcoel_defs.svh"

module dcoel_top (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // pins
  input  wire logic        outputStandbyPin,
  input  wire logic        remoteSelectPin_n,
  input  wire logic [11:0] currentSetpointInput,
  input  wire logic [11:0] powerSetpointInput,
  input  wire logic [11:0] voltageSetpointInput,
  input  wire logic [4:0]  eventCond,
  input  wire logic        overtempAlarm,
  input  wire logic        supplyFailAlarm,
  input  wire logic        protectAlarm,
  output logic             dcOutputOn,
  output logic [11:0]      currentSetpointOut,
  output logic [11:0]      powerSetpointOut,
  output logic [11:0]      voltageSetpointOut,
  output logic             setpointRemote,
  output logic             alarmLatched,
  output logic             soundOut,
  // axi4-lite
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    dcoel_pkg::dcoel_st_t  mode;
    logic                  pinPrev;
    logic                  pinReq;
    logic                  alarmLatch;
    logic                  autoHold;
    logic                  ackLow;
    logic [19:0]           ackCnt;
    logic [3:0]            ctrl;
    logic [9:0]            evtAct;
    dcoel_pkg::dcoel_ind_t ind;
    logic                  awHave;
    logic [7:0]            awAddr;
    logic                  wHave;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic                  bValid;
    logic [1:0]            bResp;
    logic                  rValid;
    logic [31:0]           rData;
    logic [1:0]            rResp;
    logic [11:0]           curSp;
    logic [11:0]           powSp;
    logic [11:0]           volSp;
  } dcoel_state_t;

  dcoel_state_t st_r;
  dcoel_state_t st_nxt;

  logic standbyDeb;
  logic remoteDeb_n;

  // ---------------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------------
  // both pins synchronised and filtered before use
  dcoel_debounce #(.CYC(`DCOEL_DEB_CYC)) uStandby (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (outputStandbyPin),
    .rstLevel (1'b1),
    .pinOut   (standbyDeb)
  );

  dcoel_debounce #(.CYC(`DCOEL_DEB_CYC)) uRemote (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinIn    (remoteSelectPin_n),
    .rstLevel (1'b1),
    .pinOut   (remoteDeb_n)
  );

  // ---------------------------------------------------------------------
  // decoded levels and bus strobes
  // ---------------------------------------------------------------------
  logic       remoteAct;
  logic       pinRelease;
  logic       wrFire;
  logic       rdFire;
  logic       cmdOn;
  logic       cmdOff;
  logic       cmdAck;
  logic       cmdErrClr;
  logic       causeActive;
  logic       protTrip;
  logic [4:0] evtHit;
  logic       evtAlarm;
  logic       evtWarn;

  // polarity swaps the meaning of the pin level
  assign pinRelease = st_r.ctrl[`DCOEL_CTRL_INV] ? ~standbyDeb : standbyDeb;
  assign remoteAct  = ~remoteDeb_n;
  assign wrFire     = st_r.awHave && st_r.wHave && !st_r.bValid;
  assign rdFire     = s_axi_arvalid && s_axi_arready;
  assign cmdOn      = wrFire && st_r.awAddr == `DCOEL_OFF_CMD
                      && st_r.wStrb[0] && st_r.wData[`DCOEL_CMD_ON];
  assign cmdOff     = wrFire && st_r.awAddr == `DCOEL_OFF_CMD
                      && st_r.wStrb[0] && st_r.wData[`DCOEL_CMD_OFF];
  assign cmdAck     = wrFire && st_r.awAddr == `DCOEL_OFF_CMD
                      && st_r.wStrb[0] && st_r.wData[`DCOEL_CMD_ACK];
  assign cmdErrClr  = wrFire && st_r.awAddr == `DCOEL_OFF_CMD
                      && st_r.wStrb[0] && st_r.wData[`DCOEL_CMD_ERRCLR];
  assign causeActive = overtempAlarm || supplyFailAlarm || protectAlarm;
  assign protTrip   = causeActive;

  // events seen only while the output is on and not disabled
  always_comb begin
    evtHit   = 5'h00;
    evtAlarm = 1'b0;
    evtWarn  = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (dcOutputOn && eventCond[i]
          && st_r.evtAct[2*i +: 2] != dcoel_pkg::ACT_NONE) begin
        evtHit[i] = 1'b1;
        if (st_r.evtAct[2*i +: 2] == dcoel_pkg::ACT_WARNING) begin
          evtWarn = 1'b1;
        end
        if (st_r.evtAct[2*i +: 2] == dcoel_pkg::ACT_ALARM) begin
          evtAlarm = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  // output control, alarms, events and register slave
  always_comb begin
    st_nxt = st_r;
    st_nxt.pinPrev = pinRelease;
    // error flag clear comes first so a refusal in the same cycle wins
    if (cmdErrClr) begin
      st_nxt.ind.errRefused = 1'b0;
    end

    // output state machine
    unique case (st_r.mode)
      dcoel_pkg::ST_OFF: begin
        if (remoteAct) begin
          // open pin reads high, so entry may switch on at once
          st_nxt.mode = dcoel_pkg::ST_REMOTE;
        end else if (cmdOn) begin
          if (pinRelease && !st_r.alarmLatch) begin
            st_nxt.mode = dcoel_pkg::ST_ON;
          end else if (!pinRelease) begin
            st_nxt.ind.errRefused = 1'b1;
          end
        end
      end
      dcoel_pkg::ST_ON: begin
        if (remoteAct) begin
          st_nxt.mode = dcoel_pkg::ST_REMOTE;
        end else if (!pinRelease) begin
          st_nxt.mode   = dcoel_pkg::ST_LOCKED;
          st_nxt.pinReq = 1'b1;
        end else if (cmdOff) begin
          st_nxt.mode = dcoel_pkg::ST_OFF;
        end
      end
      dcoel_pkg::ST_LOCKED: begin
        if (remoteAct) begin
          st_nxt.mode   = dcoel_pkg::ST_REMOTE;
          st_nxt.pinReq = 1'b0;
        end else if (cmdOff) begin
          st_nxt.pinReq = 1'b0;
        end else if (cmdOn) begin
          st_nxt.ind.errRefused = 1'b1;
        end
        if (!remoteAct && pinRelease) begin
          // release restores the output if still requested
          st_nxt.mode = (st_r.pinReq && !cmdOff && !st_r.alarmLatch)
                        ? dcoel_pkg::ST_ON : dcoel_pkg::ST_OFF;
          st_nxt.pinReq = 1'b0;
        end
      end
      dcoel_pkg::ST_REMOTE: begin
        if (!remoteAct) begin
          st_nxt.mode = dcoel_pkg::ST_OFF;
        end
      end
    endcase

    // alarm latching and auto resume hold
    if (protTrip) begin
      st_nxt.alarmLatch = 1'b1;
      if ((overtempAlarm && st_r.ctrl[`DCOEL_CTRL_OTAUTO])
          || (supplyFailAlarm && st_r.ctrl[`DCOEL_CTRL_PFAUTO])) begin
        if (dcOutputOn) begin
          st_nxt.autoHold = 1'b1;
        end
      end
    end
    if (evtAlarm) begin
      st_nxt.alarmLatch = 1'b1;
    end

    // remote ack: low for the full window then high
    if (remoteAct && !pinRelease) begin
      if (st_r.ackCnt != 20'(`DCOEL_ACK_LOW_CYC)) begin
        st_nxt.ackCnt = st_r.ackCnt + 20'h00001;
      end
    end else begin
      st_nxt.ackCnt = 20'h00000;
    end
    st_nxt.ackLow = remoteAct && pinRelease && !st_r.pinPrev
                    && st_r.ackCnt == 20'(`DCOEL_ACK_LOW_CYC);

    // acknowledge accepted only with the cause gone
    if ((cmdAck || st_r.ackLow) && !causeActive) begin
      st_nxt.alarmLatch = 1'b0;
      st_nxt.ind.alarmNotice = 1'b0;
      st_nxt.ind.warnNotice  = 1'b0;
    end

    // auto resume after overtemp or supply fail clears
    if (st_r.autoHold && !causeActive) begin
      st_nxt.autoHold = 1'b0;
      if (st_r.mode == dcoel_pkg::ST_OFF && pinRelease) begin
        st_nxt.mode = dcoel_pkg::ST_ON;
      end
    end

    // forced off by alarms
    if ((protTrip || evtAlarm) && st_r.mode != dcoel_pkg::ST_REMOTE) begin
      st_nxt.mode   = dcoel_pkg::ST_OFF;
      st_nxt.pinReq = 1'b0;
    end

    // indications; set wins over clear
    if (cmdErrClr) begin
      st_nxt.ind.evtText    = 5'h00;
    end
    st_nxt.ind.evtText = st_nxt.ind.evtText | evtHit;
    if (evtWarn) begin
      st_nxt.ind.warnNotice = 1'b1;
    end
    if (evtAlarm || protTrip) begin
      st_nxt.ind.alarmNotice = 1'b1;
    end
    st_nxt.ind.sound = st_r.ctrl[`DCOEL_CTRL_SOUND]
                       && (evtWarn || evtAlarm || protTrip);

    // setpoints pass only under remote control
    if (remoteAct) begin
      st_nxt.curSp = currentSetpointInput;
      st_nxt.powSp = powerSetpointInput;
      st_nxt.volSp = voltageSetpointInput;
    end

    // axi write channel capture
    if (s_axi_awvalid && !st_r.awHave) begin
      st_nxt.awHave = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.wHave) begin
      st_nxt.wHave = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (wrFire) begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = 2'h0;
      unique case (st_r.awAddr)
        `DCOEL_OFF_CTRL: begin
          if (st_r.wStrb[0]) begin
            st_nxt.ctrl = st_r.wData[3:0];
          end
        end
        `DCOEL_OFF_EVT: begin
          if (st_r.wStrb[0]) begin
            st_nxt.evtAct[7:0] = st_r.wData[7:0];
          end
          if (st_r.wStrb[1]) begin
            st_nxt.evtAct[9:8] = st_r.wData[9:8];
          end
        end
        `DCOEL_OFF_CMD: begin
        end
        default: begin
          st_nxt.bResp = 2'h2; // unmapped: slverr
        end
      endcase
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end

    // axi read
    if (rdFire) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = 2'h0;
      unique case (s_axi_araddr)
        `DCOEL_OFF_CTRL: st_nxt.rData = {28'h0000000, st_r.ctrl};
        `DCOEL_OFF_CMD:  st_nxt.rData = 32'h00000000;
        `DCOEL_OFF_EVT:  st_nxt.rData = {22'h000000, st_r.evtAct};
        `DCOEL_OFF_STAT: st_nxt.rData = {15'h0000, st_r.ind.evtText,
                                         st_r.mode, remoteAct, standbyDeb,
                                         st_r.pinReq, st_r.autoHold,
                                         st_r.alarmLatch,
                                         st_r.ind.errRefused,
                                         st_r.ind.warnNotice,
                                         st_r.ind.alarmNotice};
        default: begin
          st_nxt.rData = 32'h00000000;
          st_nxt.rResp = 2'h2;
        end
      endcase
    end else if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  // reset: output off, nothing latched, ctrl cleared to normal polarity
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{mode: dcoel_pkg::ST_OFF, pinPrev: 1'b1,
                ctrl: `DCOEL_CTRL_RST, evtAct: `DCOEL_EVT_RST,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  // in remote the pin level decides the output unless an alarm is latched
  assign dcOutputOn = (st_r.mode == dcoel_pkg::ST_ON)
                      || (st_r.mode == dcoel_pkg::ST_REMOTE && pinRelease
                          && !st_r.alarmLatch);
  assign currentSetpointOut = st_r.curSp;
  assign powerSetpointOut   = st_r.powSp;
  assign voltageSetpointOut = st_r.volSp;
  assign setpointRemote     = remoteAct;
  assign alarmLatched       = st_r.alarmLatch;
  assign soundOut           = st_r.ind.sound;
  assign s_axi_awready      = !st_r.awHave;
  assign s_axi_wready       = !st_r.wHave;
  assign s_axi_bvalid       = st_r.bValid;
  assign s_axi_bresp        = st_r.bResp;
  assign s_axi_arready      = !st_r.rValid;
  assign s_axi_rvalid       = st_r.rValid;
  assign s_axi_rdata        = st_r.rData;
  assign s_axi_rresp        = st_r.rResp;

endmodule
`default_nettype wire

/* File: rtl/dcoel_defs.svh */
// constants of the dc output enable and lock control
// assumes a 10 MHz core clock and synchronous pin inputs
//
// Operation
// - remote mode: standby pin sets output unless alarm latched
// - standby pin polarity normal or inverted
// - open pin reads high, requests output on
// - unlocked pin level permits manual switch-on
// - locked pin refuses switch-on, flags error
// - output on, unlocked: requests still accepted
// - lock edge turns off; release restores on
// - off command cancels pending pin switch-on
// - setpoints honoured only while remote active
// - event actions: NONE disables, SIGNAL texts
// - WARNING: text, warning, sound, output stays
// - ALARM: text, alarm, sound, output off
// - alarm ack only after cause clears
// - overtemp/supply-fail optional auto resume
// - events evaluated only while output on
`ifndef DCOEL_DEFS_SVH
`define DCOEL_DEFS_SVH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define DCOEL_CLK_HZ        10000000
`define DCOEL_DEB_US        1000
`define DCOEL_DEB_CYC       ((`DCOEL_CLK_HZ / 1000000) * `DCOEL_DEB_US)
`define DCOEL_ACK_LOW_MS    50
`define DCOEL_ACK_LOW_CYC   ((`DCOEL_CLK_HZ / 1000) * `DCOEL_ACK_LOW_MS)

// ---------------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------------
`define DCOEL_OFF_CTRL      8'h00
`define DCOEL_OFF_CMD       8'h04
`define DCOEL_OFF_EVT       8'h08
`define DCOEL_OFF_STAT      8'h0C

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define DCOEL_CTRL_INV      0
`define DCOEL_CTRL_SOUND    1
`define DCOEL_CTRL_OTAUTO   2
`define DCOEL_CTRL_PFAUTO   3
`define DCOEL_CMD_ON        0
`define DCOEL_CMD_OFF       1
`define DCOEL_CMD_ACK       2
`define DCOEL_CMD_ERRCLR    3

// ---------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------
`define DCOEL_CTRL_RST      4'h0
`define DCOEL_EVT_RST       10'h000

`endif

/* File: rtl/dcoel_pkg.sv */
// types of the dc output enable and lock control
// assumes the constants header is included by the design files
package dcoel_pkg;

  // user event action
  typedef enum logic [1:0] {
    ACT_NONE    = 2'h0,
    ACT_SIGNAL  = 2'h1,
    ACT_WARNING = 2'h2,
    ACT_ALARM   = 2'h3
  } dcoel_act_t;

  // output state
  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_ON     = 4'h2,
    ST_LOCKED = 4'h4,
    ST_REMOTE = 4'h8
  } dcoel_st_t;

  // indications
  typedef struct packed {
    logic [4:0] evtText;
    logic       warnNotice;
    logic       alarmNotice;
    logic       sound;
    logic       errRefused;
  } dcoel_ind_t;

endpackage

/* File: rtl/dcoel_debounce.sv */
// debouncer for one slow digital pin
// assumes the pin is already synchronous to the clock
`timescale 1ns/1ns
`default_nettype none
`include "dcoel_defs.svh"

module dcoel_debounce #(
  parameter int unsigned CYC = 10
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  input  wire logic rstLevel,
  output logic      pinOut
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [15:0] cnt;
    logic        lvl;
  } dcoel_deb_st_t;

  dcoel_deb_st_t st_r;
  dcoel_deb_st_t st_nxt;

  // two stage sync then stable-for-CYC filter
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2 == st_r.lvl) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt == 16'(CYC - 1)) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.lvl = st_r.s2;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  // reset takes the open-pin level (high)
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 16'h0000, lvl: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pinOut = st_r.lvl;

endmodule
`default_nettype wire

/* File: dv/dcoel_asserts.sv */
// checker of the dc output enable control
// assumes one clock domain; bound from the testbench top
`timescale 1ns/1ns
`default_nettype none
module dcoel_asserts (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        outputStandbyPin,
  input wire logic        overtempAlarm,
  input wire logic        supplyFailAlarm,
  input wire logic        protectAlarm,
  input wire logic        dcOutputOn,
  input wire logic [11:0] currentSetpointOut,
  input wire logic        setpointRemote,
  input wire logic        alarmLatched,
  input wire logic        soundOut,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  logic        pinQ_r;
  logic [15:0] quiet_r;
  logic [3:0]  wrAge_r;
  logic        anyAlarm;
  assign anyAlarm = overtempAlarm || supplyFailAlarm || protectAlarm;
  // quiet time of the pin in remote mode, age of last write data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinQ_r  <= 1'b1;
      quiet_r <= 16'h0000;
      wrAge_r <= 4'hF;
    end else begin
      pinQ_r <= outputStandbyPin;
      if (pinQ_r != outputStandbyPin || !setpointRemote)
        quiet_r <= 16'h0000;
      else if (quiet_r != 16'hFFFF)
        quiet_r <= quiet_r + 16'h0001;
      if (s_axi_wvalid && s_axi_wready)
        wrAge_r <= 4'h0;
      else if (wrAge_r != 4'hF)
        wrAge_r <= wrAge_r + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_alarm_held;
    anyAlarm [*4];
  endsequence
  sequence s_wr_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence
  a_reset_state: assert property (
    $rose(arst_n) |-> !dcOutputOn && !alarmLatched && !soundOut)
    else $error("state not clean after reset");
  a_sp_frozen: assert property (
    !setpointRemote [*2] |-> $stable(currentSetpointOut))
    else $error("setpoint moved outside remote");
  a_remote_hold: assert property (
    setpointRemote && quiet_r > 16'h2774 && !anyAlarm
      |-> $stable(dcOutputOn))
    else $error("output moved without pin change in remote");
  a_alarm_off: assert property (
    s_alarm_held |-> !dcOutputOn)
    else $error("output on during alarm");
  a_ack_clear: assert property (
    $fell(alarmLatched) |-> !anyAlarm)
    else $error("alarm acknowledged while cause present");
  a_latch_ack: assert property (
    $fell(alarmLatched) |-> setpointRemote || wrAge_r < 4'h4)
    else $error("alarm latch cleared without ack");
  a_write_resp: assert property (
    s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
endmodule
`default_nettype wire

/* File: dv/dcoel_contact_model.sv */
// open-collector contacts on the standby and remote pins
// assumes pull-ups inside the device; changes follow the clock
`timescale 1ns/1ns
`default_nettype none
module dcoel_contact_model (
  input  wire logic core_clk,
  input  wire logic sbClose,
  input  wire logic remClose,
  output var logic  sbPin = 1'b1,
  output var logic  remPin_n = 1'b1
);
  // open contact leaves the pulled-up pin high; ack is high-low-high
  always @(posedge core_clk) begin
    sbPin    <= !sbClose;
    remPin_n <= !remClose;
  end
endmodule
`default_nettype wire

/* File: dv/dc_output_enable_lock_control_test.sv */
// testbench of the dc output enable control
// assumes the contact model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "dcoel_defs.svh"
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module dc_output_enable_lock_control_test;
  logic        core_clk, arst_n, sbClose, remClose;
  logic        outputStandbyPin, remoteSelectPin_n;
  logic [11:0] currentSetpointInput, powerSetpointInput;
  logic [11:0] voltageSetpointInput, currentSetpointOut;
  logic [11:0] powerSetpointOut, voltageSetpointOut;
  logic [4:0]  eventCond;
  logic        overtempAlarm, supplyFailAlarm, protectAlarm;
  logic        dcOutputOn, setpointRemote, alarmLatched, soundOut;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          errCount, nTests;
  dcoel_contact_model pins (.core_clk(core_clk), .sbClose(sbClose),
    .remClose(remClose), .sbPin(outputStandbyPin),
    .remPin_n(remoteSelectPin_n));
  dcoel_top dut (.*);
  // ---------------------------------------------------------------
  // bus and helper tasks
  // ---------------------------------------------------------------
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #10;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 64 && !s_axi_bvalid; n++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 64) begin errCount++; testDone(); end
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 64 && !s_axi_rvalid; n++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 64) begin errCount++; testDone(); end
  endtask
  task automatic cmd(input int b);
    wr(`DCOEL_OFF_CMD, 32'h1 << b);
    wt(4);
  endtask
  task automatic pin(input logic c);
    sbClose = c;
    wt(10010);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic tReset();
    `CHK(dcOutputOn, 1'b0)
    rdr(`DCOEL_OFF_STAT);
    `CHK(rd[11:8], dcoel_pkg::ST_OFF)
    `CHK(rd[3:0], 4'h0)
    rdr(`DCOEL_OFF_EVT);
    `CHK(rd[9:0], `DCOEL_EVT_RST)
    rdr(8'h10);
    `CHK({rr, rd}, {2'h2, 32'h0})
    wr(8'h10, 32'h0);
    `CHK(rr, 2'h2)
    $display("test reset done");
  endtask
  task automatic tLock();
    cmd(`DCOEL_CMD_ON);
    `CHK(dcOutputOn, 1'b1)
    cmd(`DCOEL_CMD_OFF);
    `CHK(dcOutputOn, 1'b0)
    pin(1'b1);
    cmd(`DCOEL_CMD_ON);
    `CHK(dcOutputOn, 1'b0)
    rdr(`DCOEL_OFF_STAT);
    `CHK(rd[2], 1'b1)
    cmd(`DCOEL_CMD_ERRCLR);
    wr(`DCOEL_OFF_CTRL, 32'h1 << `DCOEL_CTRL_INV);
    cmd(`DCOEL_CMD_ON);
    `CHK(dcOutputOn, 1'b1)
    cmd(`DCOEL_CMD_OFF);
    wr(`DCOEL_OFF_CTRL, 32'h0);
    pin(1'b0);
    $display("test lock done");
  endtask
  task automatic tToggle();
    cmd(`DCOEL_CMD_ON);
    pin(1'b1);
    `CHK(dcOutputOn, 1'b0)
    pin(1'b0);
    `CHK(dcOutputOn, 1'b1)
    pin(1'b1);
    cmd(`DCOEL_CMD_OFF);
    pin(1'b0);
    `CHK(dcOutputOn, 1'b0)
    $display("test toggle done");
  endtask
  task automatic tEvents();
    wr(`DCOEL_OFF_EVT, 32'h39);
    wr(`DCOEL_OFF_CTRL, 32'h1 << `DCOEL_CTRL_SOUND);
    eventCond = 5'h01;
    rdr(`DCOEL_OFF_STAT);
    `CHK(rd[16:12], 5'h00)
    eventCond = 5'h08;
    cmd(`DCOEL_CMD_ON);
    eventCond = 5'h09;
    rdr(`DCOEL_OFF_STAT);
    `CHK({dcOutputOn, rd[16:12], rd[1:0]}, 8'h84)
    eventCond = 5'h0B;
    rdr(`DCOEL_OFF_STAT);
    `CHK({dcOutputOn, soundOut, rd[1]}, 3'h7)
    eventCond = 5'h0F;
    rdr(`DCOEL_OFF_STAT);
    `CHK({dcOutputOn, rd[16:12], rd[0]}, 7'h0F)
    eventCond = 5'h00;
    cmd(`DCOEL_CMD_ACK);
    cmd(`DCOEL_CMD_ERRCLR);
    wr(`DCOEL_OFF_EVT, 32'h0);
    $display("test events done");
  endtask
  task automatic tAlarms();
    wr(`DCOEL_OFF_CTRL, 32'h1 << `DCOEL_CTRL_OTAUTO);
    cmd(`DCOEL_CMD_ON);
    overtempAlarm = 1'b1;
    wt(8);
    `CHK({dcOutputOn, alarmLatched}, 2'h1)
    overtempAlarm = 1'b0;
    wt(8);
    `CHK({dcOutputOn, alarmLatched}, 2'h3)
    cmd(`DCOEL_CMD_ACK);
    `CHK(alarmLatched, 1'b0)
    protectAlarm = 1'b1;
    cmd(`DCOEL_CMD_ACK);
    `CHK({dcOutputOn, alarmLatched}, 2'h1)
    protectAlarm = 1'b0;
    cmd(`DCOEL_CMD_ACK);
    `CHK({dcOutputOn, alarmLatched}, 2'h0)
    wr(`DCOEL_OFF_CTRL, 32'h0);
    $display("test alarms done");
  endtask
  task automatic tRemote();
    `CHK(currentSetpointOut, 12'h000)
    remClose = 1'b1;
    wt(10010);
    `CHK({setpointRemote, dcOutputOn}, 2'h3)
    `CHK(currentSetpointOut, 12'hA5C)
    `CHK(powerSetpointOut, 12'h3C7)
    `CHK(voltageSetpointOut, 12'hFFF)
    cmd(`DCOEL_CMD_OFF);
    `CHK(dcOutputOn, 1'b1)
    pin(1'b1);
    cmd(`DCOEL_CMD_ON);
    `CHK(dcOutputOn, 1'b0)
    $display("test remote done");
  endtask
  // clock of 100 ns
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // reset, then the scenarios in order
  initial begin
    {arst_n, sbClose, remClose, eventCond} = 8'h00;
    {overtempAlarm, supplyFailAlarm, protectAlarm} = 3'h0;
    currentSetpointInput = 12'hA5C;
    powerSetpointInput   = 12'h3C7;
    voltageSetpointInput = 12'hFFF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    wt(2);
    tReset();
    tLock();
    tToggle();
    tEvents();
    tAlarms();
    tRemote();
    testDone();
  end
endmodule
bind dcoel_top dcoel_asserts chk (.*);
`default_nettype wire
